/* File: rtl/sensor_cfg_pkg.sv */
package sensor_cfg_pkg;

    // Register offsets on the internal register port.
    localparam logic [7:0] ADDR_CRC_CONFIG = 8'h3D;
    localparam logic [7:0] ADDR_PRODUCT_ID = 8'h3E;
    localparam logic [7:0] ADDR_CLIENT_ADDR = 8'h3F;
    localparam logic [7:0] ADDR_DSP_FILTER = 8'h40;
    localparam logic [7:0] ADDR_DSP_DATATYPE = 8'h42;
    localparam logic [7:0] ADDR_DSP_SELFTEST = 8'h44;

    // Reset values of the stored registers.
    localparam logic [7:0] RESET_ZERO = 8'h00;
    localparam logic [7:0] RESET_DSP_FILTER = 8'h30;
    // Checksum of all covered registers at reset.
    localparam logic [7:0] RESET_ARRAY_SUM = 8'h30;

    // Identifier answered while the stored value is zero; the value is arbitrary.
    localparam logic [7:0] PRODUCT_ID_CODE = 8'hA7;
    // Client bus address used while the stored value is zero.
    localparam logic [7:0] DEFAULT_CLIENT_ADDR = 8'h60;

    // CRC length codes and generator polynomials, leading term implied.
    localparam logic [1:0] CRC_LEN_8 = 2'b00;
    localparam logic [1:0] CRC_LEN_4 = 2'b01;
    localparam logic [7:0] CRC_POLY_8 = 8'h2F;
    localparam logic [7:0] CRC_POLY_4 = 8'h01;
    localparam logic [7:0] CRC_POLY_3 = 8'h03;
    localparam logic [7:0] CRC_SEED_8 = 8'hFF;
    localparam logic [7:0] CRC_SEED_4 = 8'h0A;
    localparam logic [7:0] CRC_SEED_3 = 8'h07;

    // Field positions inside the registers.
    localparam int DATASIZE_BIT = 6;
    localparam int CRC_LEN_LSB = 4;
    localparam int FIELD_HI_LSB = 4;
    localparam int CHAN0_LSB = 5;
    localparam int CHAN1_LSB = 2;

    // Defined low-pass filter codes.
    localparam logic [3:0] LPF_800HZ = 4'h2;
    localparam logic [3:0] LPF_1000HZ = 4'h3;

    // Self-test codes that force fixed patterns.
    localparam logic [3:0] ST_PATTERN_0 = 4'h4;
    localparam logic [3:0] ST_PATTERN_A = 4'h5;
    localparam logic [3:0] ST_PATTERN_5 = 4'h6;
    localparam logic [3:0] ST_PATTERN_F = 4'h7;
    localparam logic [15:0] PATTERN_0 = 16'h0000;
    localparam logic [15:0] PATTERN_A = 16'h0AAA;
    localparam logic [15:0] PATTERN_5 = 16'h5555;
    localparam logic [15:0] PATTERN_F = 16'hFFFF;

    // One request on the register port.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // CRC settings in force for the current command.
    typedef struct packed {
        logic [1:0] len;
        logic [7:0] poly;
        logic [7:0] seed;
    } crc_active_t;

endpackage

/* File: rtl/sensor_user_config_regs.sv */
module sensor_user_config_regs (
    input wire logic core_clk,
    input wire logic reset,
    input wire sensor_cfg_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic reg_wr_refused,
    input wire logic init_done_lock,
    input wire logic spi_cmd_start,
    output sensor_cfg_pkg::crc_active_t crc_active,
    output logic spi_data_16bit,
    output logic [6:0] i2c_client_addr,
    output logic [3:0] lowpass_select,
    output logic [1:0] channel0_content_select,
    output logic [1:0] channel1_content_select,
    output logic dsp_path_reset,
    input wire logic dsp_init_done,
    output logic dsp_init_busy,
    output logic filter_code_error,
    output logic [3:0] selftest_select,
    output logic sensor_write_inhibit,
    output logic [15:0] sensor_test_pattern,
    output logic array_check_error
);
    import sensor_cfg_pkg::*;

    // Stored register values.
    logic [7:0] crc_config;
    logic [7:0] product_identifier;
    logic [7:0] client_bus_address;
    logic [7:0] dsp_filter_config;
    logic [7:0] dsp_datatype_config;
    logic [7:0] dsp_selftest_config;
    // Running checksum kept in step with every accepted write.
    logic [7:0] array_sum;
    // Write accepted this cycle.
    logic wr_ok;
    // A DSP configuration write that alters the stored value.
    logic dsp_change;
    // Checksum of the covered registers as they stand now.
    logic [7:0] live_sum;

    // Maps a configuration byte onto polynomial and seed.
    function automatic crc_active_t crc_decode(input logic [7:0] cfg);
        crc_active_t c;
        c.len = cfg[CRC_LEN_LSB +: 2];
        if (c.len == CRC_LEN_8) begin
            c.poly = CRC_POLY_8;
            c.seed = (cfg[3:0] == 4'h0) ? CRC_SEED_8 : {4'h0, cfg[3:0]};
        end else if (c.len == CRC_LEN_4) begin
            c.poly = CRC_POLY_4;
            c.seed = (cfg[3:0] == 4'h0) ? CRC_SEED_4 : {4'h0, cfg[3:0]};
        end else begin
            // Both upper length codes share the 3-bit CRC.
            // The whole seed field decides the default, so seed 8 gives a zero 3-bit seed.
            c.poly = CRC_POLY_3;
            c.seed = (cfg[3:0] == 4'h0) ? CRC_SEED_3 : {5'h00, cfg[2:0]};
        end
        return c;
    endfunction

    // A stored zero stands for a fixed default value.
    function automatic logic [7:0] zero_default(input logic [7:0] v, input logic [7:0] dflt);
        return (v == 8'h00) ? dflt : v;
    endfunction

    // Once the lock is set no write reaches the array.
    assign wr_ok = reg_req.wr && !init_done_lock;

    // Only a real change restarts the DSP; rewriting the same value is harmless.
    assign dsp_change = wr_ok && (((reg_req.addr == ADDR_DSP_FILTER) && (reg_req.wdata != dsp_filter_config))
        || ((reg_req.addr == ADDR_DSP_DATATYPE) && (reg_req.wdata != dsp_datatype_config)));

    // The self-test register is left out of the sum on purpose.
    assign live_sum = crc_config ^ product_identifier ^ client_bus_address
        ^ dsp_filter_config ^ dsp_datatype_config;

    // Register array writes.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            crc_config <= RESET_ZERO;
            product_identifier <= RESET_ZERO;
            client_bus_address <= RESET_ZERO;
            dsp_filter_config <= RESET_DSP_FILTER;
            dsp_datatype_config <= RESET_ZERO;
            dsp_selftest_config <= RESET_ZERO;
        end else if (wr_ok) begin
            case (reg_req.addr)
                ADDR_CRC_CONFIG: begin
                    crc_config <= reg_req.wdata;
                end
                ADDR_PRODUCT_ID: begin
                    product_identifier <= reg_req.wdata;
                end
                ADDR_CLIENT_ADDR: begin
                    client_bus_address <= reg_req.wdata;
                end
                ADDR_DSP_FILTER: begin
                    dsp_filter_config <= reg_req.wdata;
                end
                ADDR_DSP_DATATYPE: begin
                    dsp_datatype_config <= reg_req.wdata;
                end
                ADDR_DSP_SELFTEST: begin
                    dsp_selftest_config <= reg_req.wdata;
                end
                default: begin
                    // Unmapped writes are dropped.
                end
            endcase
        end
    end

    // Checksum follows each accepted write to a covered register.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            array_sum <= RESET_ARRAY_SUM;
        end else if (wr_ok) begin
            case (reg_req.addr)
                ADDR_CRC_CONFIG: begin
                    array_sum <= array_sum ^ crc_config ^ reg_req.wdata;
                end
                ADDR_PRODUCT_ID: begin
                    array_sum <= array_sum ^ product_identifier ^ reg_req.wdata;
                end
                ADDR_CLIENT_ADDR: begin
                    array_sum <= array_sum ^ client_bus_address ^ reg_req.wdata;
                end
                ADDR_DSP_FILTER: begin
                    array_sum <= array_sum ^ dsp_filter_config ^ reg_req.wdata;
                end
                ADDR_DSP_DATATYPE: begin
                    array_sum <= array_sum ^ dsp_datatype_config ^ reg_req.wdata;
                end
                default: begin
                    // Self-test and unmapped writes leave the sum alone.
                end
            endcase
        end
    end

    // A mismatch means a stored bit flipped; it stays until reset.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            array_check_error <= 1'b0;
        end else if (array_sum != live_sum) begin
            array_check_error <= 1'b1;
        end
    end

    // Read port, one cycle latency, unmapped reads give zero.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.rd;
            if (reg_req.rd) begin
                case (reg_req.addr)
                    ADDR_CRC_CONFIG: begin
                        reg_rdata <= crc_config;
                    end
                    ADDR_PRODUCT_ID: begin
                        reg_rdata <= zero_default(product_identifier, PRODUCT_ID_CODE);
                    end
                    ADDR_CLIENT_ADDR: begin
                        // There is no mode gate, so it reads in every interface mode.
                        reg_rdata <= zero_default(client_bus_address, DEFAULT_CLIENT_ADDR);
                    end
                    ADDR_DSP_FILTER: begin
                        reg_rdata <= dsp_filter_config;
                    end
                    ADDR_DSP_DATATYPE: begin
                        reg_rdata <= dsp_datatype_config;
                    end
                    ADDR_DSP_SELFTEST: begin
                        reg_rdata <= dsp_selftest_config;
                    end
                    default: begin
                        reg_rdata <= 8'h00;
                    end
                endcase
            end
        end
    end

    // Writes refused by the lock are signalled for one cycle.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            reg_wr_refused <= 1'b0;
        end else begin
            reg_wr_refused <= reg_req.wr && init_done_lock;
        end
    end

    // CRC settings change only at a command boundary, so no frame mixes two.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            crc_active <= crc_decode(RESET_ZERO);
            spi_data_16bit <= 1'b0;
        end else if (spi_cmd_start) begin
            crc_active <= crc_decode(crc_config);
            spi_data_16bit <= crc_config[DATASIZE_BIT];
        end
    end

    // Client bus address seen by the I2C engine.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            i2c_client_addr <= DEFAULT_CLIENT_ADDR[6:0];
        end else begin
            // The size cast drops the top bit on purpose; only seven bits form the address.
            i2c_client_addr <= 7'(zero_default(client_bus_address, DEFAULT_CLIENT_ADDR));
        end
    end

    // DSP configuration fields and the filter code check.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            lowpass_select <= LPF_1000HZ;
            channel0_content_select <= 2'b00;
            channel1_content_select <= 2'b00;
            filter_code_error <= 1'b0;
        end else begin
            lowpass_select <= dsp_filter_config[FIELD_HI_LSB +: 4];
            channel0_content_select <= dsp_datatype_config[CHAN0_LSB +: 2];
            channel1_content_select <= dsp_datatype_config[CHAN1_LSB +: 2];
            filter_code_error <= (dsp_filter_config[FIELD_HI_LSB +: 4] != LPF_800HZ)
                && (dsp_filter_config[FIELD_HI_LSB +: 4] != LPF_1000HZ);
        end
    end

    // One-cycle DSP reset and a busy level until the DSP reports ready.
    // The host must keep off sensor data while busy; nothing here blocks it.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            dsp_path_reset <= 1'b0;
            dsp_init_busy <= 1'b0;
        end else begin
            dsp_path_reset <= dsp_change;
            if (dsp_change) begin
                dsp_init_busy <= 1'b1;
            end else if (dsp_init_done) begin
                dsp_init_busy <= 1'b0;
            end
        end
    end

    // Self-test selection and the forced patterns.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            selftest_select <= 4'h0;
            sensor_write_inhibit <= 1'b0;
            sensor_test_pattern <= PATTERN_0;
        end else begin
            selftest_select <= dsp_selftest_config[FIELD_HI_LSB +: 4];
            sensor_write_inhibit <= 1'b0;
            sensor_test_pattern <= PATTERN_0;
            case (dsp_selftest_config[FIELD_HI_LSB +: 4])
                ST_PATTERN_0: begin
                    sensor_write_inhibit <= 1'b1;
                end
                ST_PATTERN_A: begin
                    sensor_write_inhibit <= 1'b1;
                    sensor_test_pattern <= PATTERN_A;
                end
                ST_PATTERN_5: begin
                    sensor_write_inhibit <= 1'b1;
                    sensor_test_pattern <= PATTERN_5;
                end
                ST_PATTERN_F: begin
                    sensor_write_inhibit <= 1'b1;
                    sensor_test_pattern <= PATTERN_F;
                end
                default: begin
                    // Other codes leave the data path free.
                end
            endcase
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    crc8_default_seed_a: assert property (
        spi_cmd_start && crc_config[5:0] == 6'h00
        |=> crc_active.poly == 8'h2F && crc_active.seed == 8'hFF)
        else $error("CRC-8 default seed wrong");

    crc4_select_a: assert property (
        spi_cmd_start && crc_config[5:4] == 2'b01 && crc_config[3:0] != 4'h0
        |=> crc_active.poly == 8'h01 && crc_active.seed == {4'h0, $past(crc_config[3:0])})
        else $error("CRC-4 settings wrong");

    crc3_default_seed_a: assert property (
        spi_cmd_start && crc_config[5] && crc_config[3:0] == 4'h0
        |=> crc_active.poly == 8'h03 && crc_active.seed == 8'h07)
        else $error("CRC-3 default seed wrong");

    crc_hold_a: assert property (
        !spi_cmd_start |=> $stable(crc_active))
        else $error("CRC settings changed mid command");

    id_default_read_a: assert property (
        reg_req.rd && reg_req.addr == 8'h3E && product_identifier == 8'h00
        |=> reg_rvalid && reg_rdata == PRODUCT_ID_CODE)
        else $error("Identifier default read wrong");

    id_stored_read_a: assert property (
        reg_req.rd && reg_req.addr == 8'h3E && product_identifier != 8'h00
        |=> reg_rdata == $past(product_identifier))
        else $error("Identifier stored read wrong");

    client_addr_default_a: assert property (
        client_bus_address == 8'h00 |=> i2c_client_addr == 7'h60)
        else $error("Default client address wrong");

    client_addr_read_a: assert property (
        reg_req.rd && reg_req.addr == 8'h3F && client_bus_address != 8'h00
        |=> reg_rdata == $past(client_bus_address)
        ##1 i2c_client_addr == $past(client_bus_address[6:0], 2))
        else $error("Client address read wrong");

    dsp_change_reset_a: assert property (
        reg_req.wr && !init_done_lock && reg_req.addr == 8'h40 && reg_req.wdata != dsp_filter_config
        |=> dsp_path_reset && dsp_init_busy ##1 !dsp_path_reset)
        else $error("DSP reset missing after change");

    lock_write_a: assert property (
        reg_req.wr && init_done_lock
        |=> reg_wr_refused && $stable(dsp_filter_config) && $stable(client_bus_address))
        else $error("Write passed the lock");

    filter_error_a: assert property (
        dsp_filter_config[7:4] != 4'h2 && dsp_filter_config[7:4] != 4'h3 |=> filter_code_error)
        else $error("Bad filter code not flagged");

    pattern_a_a: assert property (
        dsp_selftest_config[7:4] == 4'h5 |=> sensor_write_inhibit && sensor_test_pattern == 16'h0AAA)
        else $error("Self-test pattern wrong");

    cover_filter_change_c: cover property (dsp_path_reset ##[1:20] !dsp_init_busy);
    cover_crc_switch_c: cover property (spi_cmd_start && crc_config[5:4] == 2'b10);
    cover_lock_refused_c: cover property (reg_wr_refused);
    cover_id_read_c: cover property (reg_rvalid && reg_rdata == PRODUCT_ID_CODE);

endmodule

/* File: verification/dsp_init_model.sv */
// Stand-in for the DSP start-up sequence that follows a data path reset.
module dsp_init_model (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic dsp_path_reset,
    input wire logic [7:0] init_cycles,
    output logic dsp_init_done
);
    timeunit 1ns;
    timeprecision 1ns;

    // Cycles left before initialisation completes.
    logic [7:0] remaining;
    // High while an initialisation is under way.
    logic running;

    // A new reset restarts the count, so a second change mid-init lengthens the wait.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            running <= 1'b0;
            remaining <= 8'h00;
            dsp_init_done <= 1'b0;
        end else if (dsp_path_reset) begin
            running <= 1'b1;
            remaining <= init_cycles;
            dsp_init_done <= 1'b0;
        end else if (running && remaining == 8'h00) begin
            running <= 1'b0;
            dsp_init_done <= 1'b1;
        end else begin
            remaining <= running ? remaining - 8'h01 : remaining;
            dsp_init_done <= 1'b0;
        end
    end
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the user configuration register bank.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import sensor_cfg_pkg::*;

    logic core_clk, reset, init_done_lock, spi_cmd_start, dsp_init_done;
    reg_req_t reg_req;
    logic [7:0] reg_rdata, init_cycles;
    logic reg_rvalid, reg_wr_refused, spi_data_16bit;
    crc_active_t crc_active;
    logic [6:0] i2c_client_addr;
    logic [3:0] lowpass_select, selftest_select;
    logic [1:0] channel0_content_select, channel1_content_select;
    logic dsp_path_reset, dsp_init_busy, filter_code_error, sensor_write_inhibit, array_check_error;
    logic [15:0] sensor_test_pattern;
    int miscompares, cmp_count;
    // Filter codes: a change, a repeat, an undefined code, then the default again.
    logic [3:0] fcodes [4] = '{4'h2, 4'h2, 4'h5, 4'h3};
    // Channel content pairs, channel 0 in the upper half.
    logic [3:0] dtypes [4] = '{4'b0111, 4'b1101, 4'b1111, 4'b0101};
    // Self-test codes and the pattern each of the first four forces; code 0 is normal operation.
    logic [3:0] stcodes [5] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h0};
    logic [15:0] stpats [5] = '{16'h0000, 16'h0AAA, 16'h5555, 16'hFFFF, 16'h0000};

    sensor_user_config_regs DUT (.core_clk, .reset, .reg_req, .reg_rdata, .reg_rvalid, .reg_wr_refused,
        .init_done_lock, .spi_cmd_start, .crc_active, .spi_data_16bit, .i2c_client_addr, .lowpass_select,
        .channel0_content_select, .channel1_content_select, .dsp_path_reset, .dsp_init_done, .dsp_init_busy,
        .filter_code_error, .selftest_select, .sensor_write_inhibit, .sensor_test_pattern, .array_check_error);

    dsp_init_model dsp_side (.core_clk, .reset, .dsp_path_reset, .init_cycles, .dsp_init_done);

    // Free-running core clock at 10 MHz.
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Compares one value and counts the outcome.
    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One write strobe, held for exactly the taking edge.
    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge core_clk);
        reg_req <= '0;
    endtask

    // One read; the answer stands for a single cycle, so it is sampled mid-cycle.
    task automatic read_check(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge core_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge core_clk);
        reg_req <= '0;
        @(negedge core_clk);
        check(18'(reg_rvalid), 18'h0_0001);
        check(18'(reg_rdata), 18'(exp));
    endtask

    // The host keeps off sensor data until the DSP reports ready, within a bound.
    task automatic wait_dsp();
        @(posedge core_clk);
        @(negedge core_clk);
        for (int w = 0; w < 100 && dsp_init_busy !== 1'b0; w++) @(negedge core_clk);
        check(18'(dsp_init_busy), 18'h0_0000);
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Cuts a hang short; the whole sequence needs well under this many cycles.
    initial begin
        #(5000 * 100);
        miscompares++;
        test_done();
    end

    initial begin
        logic [1:0] len;
        logic [3:0] seed, code, last;
        logic [17:0] prev;
        reset = 1'b1;
        reg_req = '0;
        init_done_lock = 1'b0;
        spi_cmd_start = 1'b0;
        init_cycles = 8'h02;
        miscompares = 0;
        cmp_count = 0;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        @(negedge core_clk);
        // Values straight out of reset.
        check(crc_active, 18'h0_2FFF);
        check(18'(i2c_client_addr), 18'h0_0060);
        check(18'(lowpass_select), 18'h0_0003);
        read_check(8'h3E, 8'hA7);
        read_check(8'h3F, 8'h60);
        read_check(8'h40, 8'h30);
        read_check(8'h42, 8'h00);
        read_check(8'h50, 8'h00);
        // Identifier: boundaries of the stored range, then back to zero.
        reg_write(8'h3E, 8'h01);
        read_check(8'h3E, 8'h01);
        reg_write(8'h3E, 8'hFF);
        read_check(8'h3E, 8'hFF);
        reg_write(8'h3E, 8'h00);
        read_check(8'h3E, 8'hA7);
        // Client address: top bit set must not reach the seven-bit address.
        reg_write(8'h3F, 8'hD5);
        read_check(8'h3F, 8'hD5);
        check(18'(i2c_client_addr), 18'h0_0055);
        reg_write(8'h3F, 8'h00);
        read_check(8'h3F, 8'h60);
        check(18'(i2c_client_addr), 18'h0_0060);
        // Every length code, zero and nonzero seed; seed 8 on length 11 leaves zero low bits.
        prev = 18'h0_2FFF;
        for (int i = 0; i < 8; i++) begin
            len = i[2:1];
            seed = i[0] ? ((len == 2'b11) ? 4'h8 : 4'hD) : 4'h0;
            reg_write(8'h3D, {1'b0, i[0], len, seed});
            @(negedge core_clk);
            check(crc_active, prev);
            @(posedge core_clk);
            spi_cmd_start <= 1'b1;
            @(posedge core_clk);
            spi_cmd_start <= 1'b0;
            @(negedge core_clk);
            if (len == 2'b00) begin
                prev = {len, 8'h2F, (seed == 4'h0) ? 8'hFF : {4'h0, seed}};
            end else if (len == 2'b01) begin
                prev = {len, 8'h01, (seed == 4'h0) ? 8'h0A : {4'h0, seed}};
            end else begin
                prev = {len, 8'h03, (seed == 4'h0) ? 8'h07 : {5'h00, seed[2:0]}};
            end
            check(crc_active, prev);
            check(18'(spi_data_16bit), 18'(i[0]));
        end
        // Filter selection with a prompt and then a slow DSP.
        last = 4'h3;
        for (int i = 0; i < 4; i++) begin
            code = fcodes[i];
            init_cycles <= (i < 2) ? 8'h00 : 8'h14;
            reg_write(8'h40, {code, 4'h0});
            @(negedge core_clk);
            check(18'(dsp_path_reset), 18'(code != last));
            check(18'(dsp_init_busy), 18'(code != last));
            wait_dsp();
            check(18'(lowpass_select), 18'(code));
            check(18'(filter_code_error), 18'(code != 4'h2 && code != 4'h3));
            read_check(8'h40, {code, 4'h0});
            last = code;
        end
        // Both channel content fields in every defined combination.
        for (int i = 0; i < 4; i++) begin
            reg_write(8'h42, {1'b0, dtypes[i][3:2], 1'b0, dtypes[i][1:0], 2'b00});
            @(negedge core_clk);
            check(18'(dsp_path_reset), 18'h0_0001);
            wait_dsp();
            check(18'(channel0_content_select), 18'(dtypes[i][3:2]));
            check(18'(channel1_content_select), 18'(dtypes[i][1:0]));
        end
        // Self-test codes that force fixed patterns, then normal operation.
        for (int i = 0; i < 5; i++) begin
            reg_write(8'h44, {stcodes[i], 4'h0});
            @(posedge core_clk);
            @(negedge core_clk);
            check(18'(selftest_select), 18'(stcodes[i]));
            check(18'(sensor_write_inhibit), 18'(stcodes[i][2]));
            check(18'(sensor_test_pattern), 18'(stpats[i]));
        end
        check(18'(array_check_error), 18'h0_0000);
        // Once locked, a write is dropped and reported.
        @(posedge core_clk);
        init_done_lock <= 1'b1;
        reg_write(8'h3E, 8'h77);
        @(negedge core_clk);
        check(18'(reg_wr_refused), 18'h0_0001);
        read_check(8'h3E, 8'hA7);
        @(posedge core_clk);
        init_done_lock <= 1'b0;
        // A second reset mid-run restores the defaults.
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        @(negedge core_clk);
        check(18'(lowpass_select), 18'h0_0003);
        check(crc_active, 18'h0_2FFF);
        read_check(8'h40, 8'h30);
        test_done();
    end
endmodule
